/* File: dhct_asserts.sv */
// Checker for the timer pair: bus answer timing, control readback, pin
// parking, clear hold and interrupt masking. Bound to dhct_top at the foot.
`timescale 1ns/10ps
module dhct_asserts
  import dhct_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic              clk,
  input wire logic              resetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              timer_pin_a_out,
  input wire logic              timer_pin_a_oe_n,
  input wire logic              timer_pin_b_out,
  input wire logic              timer_pin_b_oe_n,
  input wire logic              half_b_irq_event
);
  // ==========================================================================
  // Shadow control word; settled means no control write for four cycles.
  logic [31:0] ctl;
  logic [3:0]  since;
  logic        wr_ctl;
  logic        settled;
  logic        rd_ok;
  logic        mapped;
  assign wr_ctl  = psel && penable && pready && pwrite && (paddr == DHCT_OFS_CTRL);
  assign settled = since > 4'h3;
  assign rd_ok   = pready && !pwrite && settled;
  assign mapped  = paddr inside {DHCT_OFS_CMP_B, DHCT_OFS_CTRL, DHCT_OFS_COUNT, DHCT_OFS_CMP_A};
  // Follows bus writes to the control word.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctl   <= 32'h0;
      since <= 4'h0;
    end else if (wr_ctl) begin
      ctl   <= pwdata & DHCT_CTRL_WMASK;
      since <= 4'h0;
    end else if (!settled) begin
      since <= since + 4'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ==========================================================================
  // Properties.
  setup_answer_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_single_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  unmapped_err_a: assert property (psel && !penable && !pwrite && !mapped
    |=> pslverr && prdata == 32'h0)
    else $error("unmapped read not refused");
  ctl_readback_a: assert property (rd_ok && paddr == DHCT_OFS_CTRL |-> prdata == ctl)
    else $error("control readback differs");
  b_clear_hold_a: assert property (rd_ok && paddr == DHCT_OFS_COUNT
    && ctl[27] && !ctl[31] |-> prdata[31:16] == 16'h0)
    else $error("cleared half counts");
  b_pin_park_a: assert property (settled && !ctl[31] && ctl[21:17] != 5'h0
    && !ctl[26] |-> !timer_pin_b_oe_n && timer_pin_b_out == ctl[28])
    else $error("half B pin not parked");
  a_pin_park_a: assert property (settled && ctl[5:1] != 5'h0 && !ctl[10]
    |-> !timer_pin_a_oe_n && timer_pin_a_out == ctl[12])
    else $error("half A pin not parked");
  a_pin_input_a: assert property (settled && ctl[5:1] == 5'h0 |-> timer_pin_a_oe_n)
    else $error("pin driven while it clocks");
  b_irq_mask_a: assert property (settled && !ctl[25] |-> !half_b_irq_event)
    else $error("masked interrupt event");
  cover property (wr_ctl && pwdata[31]);
  cover property (pslverr);
  cover property ($rose(timer_pin_a_out));
endmodule : dhct_asserts

bind dhct_top dhct_asserts #(.ADDR_W(ADDR_W)) u_dhct_asserts (
  .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .timer_pin_a_out(timer_pin_a_out), .timer_pin_a_oe_n(timer_pin_a_oe_n),
  .timer_pin_b_out(timer_pin_b_out), .timer_pin_b_oe_n(timer_pin_b_oe_n),
  .half_b_irq_event(half_b_irq_event));

/* File: dhct_edge.sv */
// Rising-edge detector for a group of clock-source levels.
// Assumes the levels are synchronous to clk.
`timescale 1ns/10ps
module dhct_edge #(
  parameter int N = 8
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic [N-1:0] level,
  output logic      [N-1:0] rise
);
  logic [N-1:0] level_d;

  // ==========================================================================
  // One registered pulse per low-to-high change of each level.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      level_d <= '0;
      rise    <= '0;
    end else begin
      level_d <= level;
      rise    <= level & ~level_d;
    end
  end
endmodule : dhct_edge

/* File: dhct_pkg.sv */
// Constants for the dual half counter/timer pair: register map, control
// field layout, function and clock-source codes, divider ratios.
// Assumes nothing beyond a SystemVerilog compiler.
package dhct_pkg;
  // ==========================================================================
  // Register byte offsets.
  localparam logic [7:0]  DHCT_OFS_CMP_B    = 8'h18;
  localparam logic [7:0]  DHCT_OFS_CTRL     = 8'h1C;
  localparam logic [7:0]  DHCT_OFS_COUNT    = 8'h20;
  localparam logic [7:0]  DHCT_OFS_CMP_A    = 8'h24;
  localparam logic [31:0] DHCT_RST_CTRL     = 32'h0000_0000;
  localparam logic [31:0] DHCT_RST_CMP      = 32'h0000_0000;
  localparam logic [31:0] DHCT_CTRL_WMASK   = 32'h9FFF_1FFF;
  // ==========================================================================
  // Control field positions for half A; half B sits one stride higher.
  localparam int          DHCT_LINK_BIT     = 31;
  localparam int          DHCT_HALF_STRIDE  = 16;
  localparam int          DHCT_POL_BIT      = 12;
  localparam int          DHCT_CLR_BIT      = 11;
  localparam int          DHCT_PE_BIT       = 10;
  localparam int          DHCT_IE_BIT       = 9;
  localparam int          DHCT_FN_LSB       = 6;
  localparam int          DHCT_CK_LSB       = 1;
  localparam int          DHCT_EN_BIT       = 0;
  localparam int          DHCT_LIM1_LSB     = 16;
  // ==========================================================================
  // Function codes and counter states.
  typedef enum logic [2:0] {
    DHCT_FN_COUNT_ONCE  = 3'h0,
    DHCT_FN_PERIODIC    = 3'h1,
    DHCT_FN_PULSE_ONCE  = 3'h2,
    DHCT_FN_PULSE_TRAIN = 3'h3,
    DHCT_FN_FREE_RUN    = 3'h4
  } dhct_fn_e;
  typedef enum logic {
    DHCT_ST_RUN  = 1'b0,
    DHCT_ST_HALT = 1'b1
  } dhct_state_e;
  // ==========================================================================
  // Clock-source codes and divider exponents (divide by two to the power).
  localparam logic [4:0]  DHCT_CK_PIN       = 5'h00;
  localparam logic [4:0]  DHCT_CK_STREAM    = 5'h10;
  localparam int          DHCT_CK_CODES     = 17;
  localparam int          DHCT_FAST_D8      = 3;
  localparam int          DHCT_FAST_D128    = 7;
  localparam int          DHCT_FAST_D512    = 9;
  localparam int          DHCT_FAST_D2K     = 11;
  localparam int          DHCT_XT_D2        = 1;
  localparam int          DHCT_XT_D16       = 4;
  localparam int          DHCT_XT_D256      = 8;
  localparam int          DHCT_SLOW_D2      = 1;
  localparam int          DHCT_SLOW_D32     = 5;
  localparam int          DHCT_SLOW_D1K     = 10;
  localparam int          DHCT_SLOW_D16K    = 14;
endpackage : dhct_pkg

/* File: dhct_prescale.sv */
// Free-running power-of-two prescaler stepped by oscillator edge pulses.
// Assumes step is a one-cycle pulse synchronous to clk.
`timescale 1ns/10ps
module dhct_prescale #(
  parameter int W = 14
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic         step,
  output logic      [W-1:0] count
);
  if (W < 1) begin : g_chk
    $error("dhct_prescale: W must be at least 1");
  end

  // ==========================================================================
  // Count oscillator edges; a divided tick is an edge with all low bits set.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count <= '0;
    end else if (step) begin
      count <= count + W'(1);
    end
  end
endmodule : dhct_prescale

/* File: dhct_tb_top.sv */
// Testbench for the timer pair: registers, counting functions, pin parking,
// linking and clock-source selection, all through APB.
// Assumes dhct_top with its checker bound; every source is one slow wave.
`timescale 1ns/10ps
module dhct_tb_top
  import dhct_pkg::*;
();
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        src = 1'b0;
  logic        last = 1'b0;
  logic [1:0]  sdiv = 2'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdat, c0, ev;
  logic        pready, pslverr, rerr, pa_out, pa_oen, pb_out, pb_oen, a_irq, b_irq;
  logic [31:0] pk [3] = '{32'h101E_0000, 32'h001E_0000, 32'h141E_0000};
  logic [2:0]  pe = 3'b101;
  int          n_errors = 0, num_checks = 0, rises = 0, highs = 0, irqs = 0, dr, dh, di, i;
  int          cpt [17] = '{4, 4, 32, 512, 2048, 8192, 4, 8, 64, 1024, 8, 128, 4096,
                            65536, 4, 1, 4};
  // ==========================================================================
  // Clock, a source wave of four cycles, and a monitor of the half A pin.
  always #20 clk = ~clk;
  always @(posedge clk) begin
    sdiv <= sdiv + 2'h1;
    src <= sdiv[1];
    last <= pa_out;
    if (pa_out && !last) rises <= rises + 1;
    if (pa_out) highs <= highs + 1;
    if (a_irq) irqs <= irqs + 1;
  end
  dhct_top #(.ADDR_W(8)) u_dhct_top (
    .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fast_rc_oscillator(src), .crystal_oscillator(src), .slow_rc_oscillator(src),
    .rtc_100hz(src), .converter_stream_a(src), .converter_stream_b(src),
    .timer_pin_a_in(src), .timer_pin_a_out(pa_out), .timer_pin_a_oe_n(pa_oen),
    .timer_pin_b_in(src), .timer_pin_b_out(pb_out), .timer_pin_b_oe_n(pb_oen),
    .half_a_irq_event(a_irq), .half_b_irq_event(b_irq));
  // ==========================================================================
  // Comparison, bus transfer and verdict.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rdat = prdata;
    rerr = pslverr;
    if (pready !== 1'b1) chk(32'h0, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask : rdc
  // Clears half A, then runs function fn at bus-clock rate for w cycles.
  task automatic run(input logic [31:0] fn, input logic [31:0] lim, input int w);
    apb(1'b1, DHCT_OFS_CMP_A, lim);
    apb(1'b1, DHCT_OFS_CTRL, 32'h0000_0E1F);
    apb(1'b1, DHCT_OFS_CTRL, 32'h0000_061F | (fn << 6));
    dr = rises;
    dh = highs;
    di = irqs;
    repeat (w) @(posedge clk);
    dr = rises - dr;
    dh = highs - dh;
    di = irqs - di;
  endtask : run
  task automatic end_sim();
    if (n_errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim
  // Watchdog against a hung run.
  initial begin
    repeat (90000) @(posedge clk);
    n_errors++;
    $display("wrong value at %0t: run timed out", $time);
    end_sim();
  end
  // ==========================================================================
  // Main sequence.
  initial begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    for (i = 0; i < 4; i++) rdc(DHCT_OFS_CMP_B + 8'(i * 4), 32'h0);
    apb(1'b1, DHCT_OFS_CMP_B, 32'hA5A5_5A5A);
    rdc(DHCT_OFS_CMP_B, 32'hA5A5_5A5A);
    apb(1'b1, DHCT_OFS_CTRL, 32'hFFFF_FFFF);
    rdc(DHCT_OFS_CTRL, 32'h9FFF_1FFF);
    apb(1'b1, DHCT_OFS_CTRL, 32'h0);
    apb(1'b1, DHCT_OFS_COUNT, 32'hFFFF_FFFF);
    rdc(DHCT_OFS_COUNT, 32'h0);
    apb(1'b0, 8'h04, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    // Half A free-runs, half B configured but disabled.
    apb(1'b1, DHCT_OFS_CTRL, 32'h011E_011F);
    apb(1'b0, DHCT_OFS_COUNT, 32'h0);
    c0 = rdat;
    rdc(DHCT_OFS_COUNT, {16'h0, c0[15:0] + 16'h3});
    rdc(DHCT_OFS_CTRL, 32'h011E_011F);
    // Half B enabled but held clear, then released.
    apb(1'b1, DHCT_OFS_CTRL, 32'h091F_011F);
    apb(1'b0, DHCT_OFS_COUNT, 32'h0);
    c0 = rdat;
    rdc(DHCT_OFS_COUNT, {16'h0, c0[15:0] + 16'h3});
    apb(1'b1, DHCT_OFS_CTRL, 32'h011F_011F);
    apb(1'b0, DHCT_OFS_COUNT, 32'h0);
    c0 = rdat;
    rdc(DHCT_OFS_COUNT, c0 + 32'h0003_0003);
    // Pin of half B parked or inverted by polarity.
    for (i = 0; i < 3; i++) begin
      apb(1'b1, DHCT_OFS_CTRL, pk[i]);
      repeat (3) @(posedge clk);
      chk({30'h0, pb_oen, pb_out}, {31'h0, pe[i]});
    end
    run(32'h0, 32'h5, 40);
    chk(dr, 32'h1);
    chk({31'h0, pa_out}, 32'h1);
    chk(di, 32'h1);
    apb(1'b0, DHCT_OFS_COUNT, 32'h0);
    chk({16'h0, rdat[15:0]}, 32'h5);
    run(32'h1, 32'h9, 100);
    chk(dh, dr);
    chk({31'h0, dr >= 8 && dr <= 11}, 32'h1);
    run(32'h2, 32'h0007_0003, 60);
    chk(dr, 32'h1);
    chk(dh, 32'h4);
    chk(di, 32'h1);
    run(32'h3, 32'h0007_0003, 60);
    chk({31'h0, dr >= 5}, 32'h1);
    // Linked pair carries into the upper halfword.
    apb(1'b1, DHCT_OFS_CTRL, 32'h8000_091F);
    apb(1'b1, DHCT_OFS_CTRL, 32'h8000_011F);
    repeat (65540) @(posedge clk);
    apb(1'b0, DHCT_OFS_COUNT, 32'h0);
    c0 = rdat;
    rdc(DHCT_OFS_COUNT, c0 + 32'h3);
    chk({16'h0, c0[31:16]}, 32'h1);
    // Every clock-source code, with the tick count it should give.
    for (i = 0; i < 17; i++) begin
      apb(1'b1, DHCT_OFS_CTRL, 32'h0000_0901 | (i << 1));
      apb(1'b1, DHCT_OFS_CTRL, 32'h0000_0101 | (i << 1));
      repeat (128) @(posedge clk);
      apb(1'b0, DHCT_OFS_COUNT, 32'h0);
      ev = 128 / cpt[i];
      dr = int'(rdat[15:0]) - int'(ev);
      chk({31'h0, dr >= -3 && dr <= 3}, 32'h1);
    end
    end_sim();
  end
endmodule : dhct_tb_top

/* File: dhct_top.sv */
// Dual half counter/timer pair with an APB register slave.
// Assumes oscillator, pin and stream inputs are synchronous to clk and
// slower than half its rate; the APB master follows the usual protocol.
// Notes on behaviour
// - Link bit 31 zero gives two 16-bit halves, one gives one 32-bit counter.
// - Half B polarity bit 28 set inverts the timer output on its pin.
// - Half B clear bit 27 holds its count at zero; writing zero releases it.
// - Half B output enable 26 low parks its pin at the polarity level.
// - Half B raises interrupt events only while bit 25 is one.
// - Function 0: count to limit 0, toggle output, stop.
// - Function 1: count to limit 0, restart, one counter-clock output pulse.
// - Function 2: assert at limit 0, deassert at limit 1, then stop.
// - Function 3: assert at limit 0, deassert at limit 1, restart.
// - Function 4: free-running count ignoring the limits.
// - Clock code 0 is the pin, 1 fast RC, 2 to 5 it divided.
// - Codes 6 to 9 are the crystal and it divided by 2, 16, 256.
// - Codes 0xA to 0xD are slow RC divided by 2, 32, 1024, 16K.
// - Code 0xE is the 100 Hz tick, 0xF the bus clock.
// - Code 0x10 is converter stream A for half A, B for half B.
// - A half counts only while its enable bit is one; reset disables.
// - Half A has the same controls in the lower control halfword.
// - Compare words hold limit 1 high, limit 0 low, writable, reset zero.
// - The count register returns both halves, or 32 bits when linked.
//
// Added by the designer: register access over APB.
`timescale 1ns/10ps
module dhct_top
  import dhct_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              fast_rc_oscillator,
  input  wire logic              crystal_oscillator,
  input  wire logic              slow_rc_oscillator,
  input  wire logic              rtc_100hz,
  input  wire logic              converter_stream_a,
  input  wire logic              converter_stream_b,
  input  wire logic              timer_pin_a_in,
  output logic                   timer_pin_a_out,
  output logic                   timer_pin_a_oe_n,
  input  wire logic              timer_pin_b_in,
  output logic                   timer_pin_b_out,
  output logic                   timer_pin_b_oe_n,
  output logic                   half_a_irq_event,
  output logic                   half_b_irq_event
);
  if (ADDR_W < 6) begin : g_chk
    $error("dhct_top: ADDR_W must reach the highest register offset");
  end

  typedef enum logic [2:0] {
    DHCT_SEL_NONE  = 3'h0,
    DHCT_SEL_CMP_B = 3'h1,
    DHCT_SEL_CTRL  = 3'h2,
    DHCT_SEL_COUNT = 3'h3,
    DHCT_SEL_CMP_A = 3'h4
  } dhct_sel_e;

  // ==========================================================================
  // Register storage and shared state.
  logic [31:0]  timer1_control;
  logic [31:0]  cmp [2];
  logic [31:0]  cnt [2];
  logic [1:0]   tmr_out;
  logic [1:0]   pin_q;
  logic [1:0]   pin_oe_n_q;
  logic [1:0]   irq_q;
  logic         pair_link_select;
  logic [31:0]  count_view;
  logic [7:0]   edges;
  logic [10:0]  fast_cnt;
  logic [7:0]   xt_cnt;
  logic [13:0]  slow_cnt;
  logic [15:1]  shared_tick;
  dhct_sel_e    setup_sel;
  dhct_sel_e    access_sel;

  // ==========================================================================
  // Address decode, used at the setup phase and again at the access phase.
  // Offsets are sized to the address bus, so no reversed slice is needed.
  function automatic dhct_sel_e reg_sel(input logic [ADDR_W-1:0] a);
    if (a == ADDR_W'(DHCT_OFS_CMP_B)) begin
      reg_sel = DHCT_SEL_CMP_B;
    end else if (a == ADDR_W'(DHCT_OFS_CTRL)) begin
      reg_sel = DHCT_SEL_CTRL;
    end else if (a == ADDR_W'(DHCT_OFS_COUNT)) begin
      reg_sel = DHCT_SEL_COUNT;
    end else if (a == ADDR_W'(DHCT_OFS_CMP_A)) begin
      reg_sel = DHCT_SEL_CMP_A;
    end else begin
      reg_sel = DHCT_SEL_NONE;
    end
  endfunction : reg_sel

  // Picks the tick of the selected clock-source code; unused codes never tick.
  function automatic logic src_tick(input logic [4:0]               code,
                                    input logic [DHCT_CK_CODES-1:0] ticks);
    if (int'(code) < DHCT_CK_CODES) begin
      src_tick = ticks[code];
    end else begin
      src_tick = 1'b0;
    end
  endfunction : src_tick

  assign setup_sel        = reg_sel(paddr);
  assign access_sel       = reg_sel(paddr);
  assign pair_link_select = timer1_control[DHCT_LINK_BIT];

  // Readback shows each half, or the whole linked count.
  assign count_view = pair_link_select ? cnt[0]
                                       : {cnt[1][15:0], cnt[0][15:0]};

  // ==========================================================================
  // APB slave: answer is prepared in the setup cycle, so pready is high in
  // the first access cycle; writes land at the edge that samples pready.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pready  <= 1'b1;
      pslverr <= (setup_sel == DHCT_SEL_NONE);
      if (pwrite) begin
        prdata <= 32'h0000_0000;
      end else begin
        case (setup_sel)
          DHCT_SEL_CMP_B: prdata <= cmp[1];
          DHCT_SEL_CTRL:  prdata <= timer1_control;
          DHCT_SEL_COUNT: prdata <= count_view;
          DHCT_SEL_CMP_A: prdata <= cmp[0];
          default:        prdata <= 32'h0000_0000;
        endcase
      end
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Control register; reserved bits stay zero.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      timer1_control <= DHCT_RST_CTRL;
    end else if (psel && penable && pready && pwrite
                 && access_sel == DHCT_SEL_CTRL) begin
      timer1_control <= pwdata & DHCT_CTRL_WMASK;
    end
  end

  // Compare limit registers, one per half.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cmp[0] <= DHCT_RST_CMP;
      cmp[1] <= DHCT_RST_CMP;
    end else if (psel && penable && pready && pwrite) begin
      if (access_sel == DHCT_SEL_CMP_A) begin
        cmp[0] <= pwdata;
      end else if (access_sel == DHCT_SEL_CMP_B) begin
        cmp[1] <= pwdata;
      end
    end
  end

  // ==========================================================================
  // Clock sources: edges of every source level, then oscillator prescalers.
  dhct_edge #(
    .N      (8)
  ) u_edge (
    .clk    (clk),
    .resetn (resetn),
    .level  ({converter_stream_b, converter_stream_a, timer_pin_b_in,
              timer_pin_a_in, rtc_100hz, slow_rc_oscillator,
              crystal_oscillator, fast_rc_oscillator}),
    .rise   (edges)
  );

  dhct_prescale #(
    .W      (DHCT_FAST_D2K)
  ) u_fast_pre (
    .clk    (clk),
    .resetn (resetn),
    .step   (edges[0]),
    .count  (fast_cnt)
  );

  dhct_prescale #(
    .W      (DHCT_XT_D256)
  ) u_xt_pre (
    .clk    (clk),
    .resetn (resetn),
    .step   (edges[1]),
    .count  (xt_cnt)
  );

  dhct_prescale #(
    .W      (DHCT_SLOW_D16K)
  ) u_slow_pre (
    .clk    (clk),
    .resetn (resetn),
    .step   (edges[2]),
    .count  (slow_cnt)
  );

  // Ticks shared by both halves, indexed by clock-source code.
  assign shared_tick[1]  = edges[0];
  assign shared_tick[2]  = edges[0] & (&fast_cnt[DHCT_FAST_D8-1:0]);
  assign shared_tick[3]  = edges[0] & (&fast_cnt[DHCT_FAST_D128-1:0]);
  assign shared_tick[4]  = edges[0] & (&fast_cnt[DHCT_FAST_D512-1:0]);
  assign shared_tick[5]  = edges[0] & (&fast_cnt[DHCT_FAST_D2K-1:0]);
  assign shared_tick[6]  = edges[1];
  assign shared_tick[7]  = edges[1] & (&xt_cnt[DHCT_XT_D2-1:0]);
  assign shared_tick[8]  = edges[1] & (&xt_cnt[DHCT_XT_D16-1:0]);
  assign shared_tick[9]  = edges[1] & (&xt_cnt[DHCT_XT_D256-1:0]);
  assign shared_tick[10] = edges[2] & (&slow_cnt[DHCT_SLOW_D2-1:0]);
  assign shared_tick[11] = edges[2] & (&slow_cnt[DHCT_SLOW_D32-1:0]);
  assign shared_tick[12] = edges[2] & (&slow_cnt[DHCT_SLOW_D1K-1:0]);
  assign shared_tick[13] = edges[2] & (&slow_cnt[DHCT_SLOW_D16K-1:0]);
  assign shared_tick[14] = edges[3];
  assign shared_tick[15] = 1'b1;

  // ==========================================================================
  // The two halves. Half A widens to 32 bits when linked; half B then idles.
  for (genvar h = 0; h < 2; h++) begin : g_half
    localparam int B = h * DHCT_HALF_STRIDE;
    logic [31:0]  lim0;
    logic [31:0]  lim1;
    logic [31:0]  mask;
    logic [31:0]  next_cnt;
    logic [4:0]   ck_sel;
    logic         wide;
    logic         tick;
    logic         go;
    logic         hit0;
    logic         hit1;
    logic         clr;
    dhct_fn_e     fn;
    dhct_state_e  st;

    assign wide     = (h == 0) && pair_link_select;
    assign mask     = wide ? 32'hFFFF_FFFF : 32'h0000_FFFF;
    assign lim0     = wide ? {cmp[1][15:0], cmp[0][15:0]}
                           : {16'h0000, cmp[h][15:0]};
    assign lim1     = wide ? {cmp[1][31:16], cmp[0][31:16]}
                           : {16'h0000, cmp[h][31:16]};
    assign ck_sel   = timer1_control[B+DHCT_CK_LSB +: 5];
    assign fn       = dhct_fn_e'(timer1_control[B+DHCT_FN_LSB +: 3]);
    assign clr      = timer1_control[B+DHCT_CLR_BIT];
    // Code 0 is this half's pin and code 0x10 this half's stream.
    assign tick     = src_tick(ck_sel, {edges[6+h], shared_tick, edges[4+h]})
                      && !(h == 1 && pair_link_select);
    assign go       = tick && timer1_control[B+DHCT_EN_BIT]
                      && !clr && (st == DHCT_ST_RUN);
    assign hit0     = (cnt[h] == lim0);
    assign hit1     = (cnt[h] == lim1);
    assign next_cnt = (cnt[h] + 32'h0000_0001) & mask;

    // Count, output level and run state; clear wins over everything.
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        cnt[h]     <= 32'h0000_0000;
        tmr_out[h] <= 1'b0;
        st         <= DHCT_ST_RUN;
      end else if (clr) begin
        cnt[h]     <= 32'h0000_0000;
        tmr_out[h] <= 1'b0;
        st         <= DHCT_ST_RUN;
      end else if (go) begin
        case (fn)
          DHCT_FN_COUNT_ONCE: begin
            if (hit0) begin
              tmr_out[h] <= ~tmr_out[h];
              st         <= DHCT_ST_HALT;
            end else begin
              cnt[h] <= next_cnt;
            end
          end
          DHCT_FN_PERIODIC: begin
            if (hit0) begin
              cnt[h]     <= 32'h0000_0000;
              tmr_out[h] <= 1'b1;
            end else begin
              cnt[h]     <= next_cnt;
              tmr_out[h] <= 1'b0;
            end
          end
          DHCT_FN_PULSE_ONCE, DHCT_FN_PULSE_TRAIN: begin
            if (hit0 && !tmr_out[h]) begin
              tmr_out[h] <= 1'b1;
              cnt[h]     <= next_cnt;
            end else if (hit1 && tmr_out[h]) begin
              tmr_out[h] <= 1'b0;
              if (fn == DHCT_FN_PULSE_ONCE) begin
                st <= DHCT_ST_HALT;
              end else begin
                cnt[h] <= 32'h0000_0000;
              end
            end else begin
              cnt[h] <= next_cnt;
            end
          end
          DHCT_FN_FREE_RUN: begin
            cnt[h] <= next_cnt;
          end
          default: begin
            cnt[h] <= cnt[h];
          end
        endcase
      end
    end

    // One-cycle interrupt event when limit 0 is reached.
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        irq_q[h] <= 1'b0;
      end else begin
        irq_q[h] <= go && hit0 && timer1_control[B+DHCT_IE_BIT];
      end
    end

    // Pin drive: parked at polarity unless enabled; released as clock input.
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        pin_q[h]      <= 1'b0;
        pin_oe_n_q[h] <= 1'b1;
      end else begin
        if (timer1_control[B+DHCT_PE_BIT]) begin
          pin_q[h] <= tmr_out[h] ^ timer1_control[B+DHCT_POL_BIT];
        end else begin
          pin_q[h] <= timer1_control[B+DHCT_POL_BIT];
        end
        pin_oe_n_q[h] <= (ck_sel == DHCT_CK_PIN);
      end
    end
  end

  // ==========================================================================
  // Port outputs, all straight from flip-flops.
  assign timer_pin_a_out  = pin_q[0];
  assign timer_pin_a_oe_n = pin_oe_n_q[0];
  assign timer_pin_b_out  = pin_q[1];
  assign timer_pin_b_oe_n = pin_oe_n_q[1];
  assign half_a_irq_event = irq_q[0];
  assign half_b_irq_event = irq_q[1];
endmodule : dhct_top
